// [hdl/sioe_top.sv]
`timescale 1ns/10ps
`include "sioe_regs.svh"
// What this block does
// - Transfer length is configuration bits 0-7 plus one, so 19 gives 20 bits.
// - With configuration bit 9 set a new transfer starts by itself after each one ends, once the receive buffer has room.
// - With configuration bit 10 set chip select stays low after a transfer ends.
// - Configuration bit 11 flags new receive data and clears once the last buffered receive word is read.
// - Bits 12 and 13 choose serial clock polarity and sampling phase in SPI extension mode.
// - Serial clock period is configuration bits 16-23 in units of 100 ns.
// - Bit 28 set runs the port as SPI extension, clear as the LED/switch interface.
// - Writing transmit data starts shifting it out once the port is idle and the receive buffer has room.
// - Captured bits appear in receive data, as wide as the configured transfer.
module sioe_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire sioe_pkg::sioe_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire sioe_pkg::sioe_word_t reg_wdata,
    output sioe_pkg::sioe_word_t reg_rdata,
    output logic reg_rvalid,
    output logic spi_sclk,
    output logic spi_mosi,
    output logic spi_cs_n,
    input wire logic spi_miso,
    output logic led_mode
);
    import sioe_pkg::*;

    sioe_state_e state_reg;
    sioe_word_t cfg_reg, tx_reg, tx_sh_reg, rx_sh_reg;
    sioe_word_t fifo_mem [0:1];
    logic [1:0] miso_sync_reg;
    logic [1:0] fifo_cnt_reg;
    logic wr_ptr_reg, rd_ptr_reg;
    logic start_pend_reg;
    logic [10:0] half_cnt_reg;
    logic [8:0] edge_reg;

    logic [7:0] len;
    logic [7:0] period;
    logic spi_mode, cpol, cpha, hold, leading;
    logic [10:0] half_prod, half_cycles;
    logic [8:0] nedges;
    logic half_tick, room, rd_rx, push, pop, do_shift, do_sample;
    sioe_word_t rx_mask;

    assign len = cfg_reg[`SIOE_LEN_MSB:`SIOE_LEN_LSB];
    assign nedges = 9'({1'b0, len} + 9'h001) << 1;
    // LED/switch mode forces clock mode 0
    assign spi_mode = cfg_reg[`SIOE_MODE_BIT];
    assign cpol = spi_mode & cfg_reg[`SIOE_CPOL_BIT];
    assign cpha = spi_mode & cfg_reg[`SIOE_CPHA_BIT];
    assign hold = cfg_reg[`SIOE_HOLD_BIT];
    // Half period from 100 ns units
    assign period = cfg_reg[`SIOE_PER_MSB:`SIOE_PER_LSB];
    assign half_prod = 11'({3'h0, period} * 11'(`SIOE_UNIT_CYC));
    // Zero or odd periods round to whole cycles, never below one
    assign half_cycles = (half_prod[10:1] == 10'h000) ? 11'h001 : {1'b0, half_prod[10:1]};
    assign half_tick = (state_reg != SIOE_IDLE) && (state_reg != SIOE_DONE)
        && (half_cnt_reg == half_cycles - 11'h001);
    assign leading = ~edge_reg[0];
    assign do_shift = half_tick && (state_reg == SIOE_SHIFT)
        && ((!cpha && !leading) || (cpha && leading && edge_reg != 9'h000));
    assign do_sample = half_tick && (state_reg == SIOE_SHIFT) && (cpha ^ leading);
    assign room = fifo_cnt_reg != 2'h2;
    assign rd_rx = reg_rd && (reg_addr == `SIOE_ADDR_RX);
    assign pop = rd_rx && (fifo_cnt_reg != 2'h0);
    assign push = (state_reg == SIOE_DONE);
    assign rx_mask = ~(32'hfffffffe << len);

    // Miso is a pin, two flops before use
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            miso_sync_reg <= 2'h0;
        end else begin
            miso_sync_reg <= {miso_sync_reg[0], spi_miso};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cfg_reg <= `SIOE_CFG_RST;
            tx_reg <= `SIOE_TX_RST;
        end else if (reg_wr && reg_addr == `SIOE_ADDR_CFG) begin
            cfg_reg <= reg_wdata & `SIOE_CFG_WMASK;
        end else if (reg_wr && reg_addr == `SIOE_ADDR_TX) begin
            tx_reg <= reg_wdata;
        end
    end

    // Set wins over the clear taken at start
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            start_pend_reg <= 1'b0;
        end else if (reg_wr && reg_addr == `SIOE_ADDR_TX) begin
            start_pend_reg <= 1'b1;
        end else if (push && cfg_reg[`SIOE_RESTART_BIT]) begin
            start_pend_reg <= 1'b1;
        end else if (state_reg == SIOE_IDLE && room) begin
            start_pend_reg <= 1'b0;
        end
    end

    // Full buffer stalls the next start, so no word is lost
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg <= SIOE_IDLE;
            half_cnt_reg <= 11'h000;
            edge_reg <= 9'h000;
        end else begin
            half_cnt_reg <= half_tick ? 11'h000 : half_cnt_reg + 11'h001;
            case (state_reg)
                SIOE_IDLE: begin
                    half_cnt_reg <= 11'h000;
                    edge_reg <= 9'h000;
                    if (start_pend_reg && room) begin
                        state_reg <= SIOE_LEAD;
                    end
                end
                SIOE_LEAD: begin
                    if (half_tick) begin
                        state_reg <= SIOE_SHIFT;
                    end
                end
                SIOE_SHIFT: begin
                    if (half_tick) begin
                        edge_reg <= edge_reg + 9'h001;
                        if (edge_reg == nedges - 9'h001) begin
                            state_reg <= SIOE_TAIL;
                        end
                    end
                end
                SIOE_TAIL: begin
                    if (half_tick) begin
                        state_reg <= SIOE_DONE;
                    end
                end
                SIOE_DONE: begin
                    state_reg <= SIOE_IDLE;
                end
                default: begin
                    state_reg <= SIOE_IDLE;
                end
            endcase
        end
    end

    // Clock toggles from its idle level
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            spi_sclk <= 1'b0;
        end else if (state_reg == SIOE_SHIFT) begin
            spi_sclk <= half_tick ? ~spi_sclk : spi_sclk;
        end else begin
            spi_sclk <= cpol;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            spi_cs_n <= 1'b1;
        end else if (state_reg == SIOE_IDLE && start_pend_reg && room) begin
            spi_cs_n <= 1'b0;
        end else if (state_reg == SIOE_DONE || state_reg == SIOE_IDLE) begin
            spi_cs_n <= hold ? spi_cs_n & (state_reg != SIOE_DONE) : 1'b1;
        end
    end

    // Msb first; the word is left aligned so bit len leaves first
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tx_sh_reg <= 32'h00000000;
            rx_sh_reg <= 32'h00000000;
        end else if (state_reg == SIOE_IDLE) begin
            tx_sh_reg <= tx_reg << (5'h1f - len[4:0]);
        end else begin
            if (do_shift) begin
                tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
            end
            if (do_sample) begin
                rx_sh_reg <= {rx_sh_reg[30:0], miso_sync_reg[1]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            spi_mosi <= 1'b0;
            led_mode <= 1'b1;
        end else begin
            spi_mosi <= tx_sh_reg[31];
            led_mode <= ~spi_mode;
        end
    end

    // Two-entry receive buffer, width follows length
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fifo_cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                fifo_mem[wr_ptr_reg] <= rx_sh_reg & rx_mask;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            case (reg_addr)
                `SIOE_ADDR_CFG: begin
                    reg_rdata <= cfg_reg | {20'h0, fifo_cnt_reg != 2'h0, 11'h0};
                end
                `SIOE_ADDR_TX: begin
                    reg_rdata <= tx_reg;
                end
                `SIOE_ADDR_RX: begin
                    reg_rdata <= (fifo_cnt_reg != 2'h0) ? fifo_mem[rd_ptr_reg] : 32'h00000000;
                end
                default: begin
                    reg_rdata <= 32'h00000000;
                end
            endcase
        end
    end

    // Clocks since the serial clock last moved, for the period check
    logic [10:0] sclk_age_reg, exp_half;
    logic sclk_last_reg;
    assign exp_half = (period == 8'h00) ? 11'h001
        : 11'((32'(period) * `SIOE_PER_UNIT_NS) / (2 * `SIOE_CLK_NS));
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sclk_last_reg <= 1'b0;
            sclk_age_reg <= 11'h000;
        end else begin
            sclk_last_reg <= spi_sclk;
            sclk_age_reg <= (spi_sclk != sclk_last_reg) ? 11'h001 : sclk_age_reg + 11'h001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_tx_write;
        reg_wr && reg_addr == `SIOE_ADDR_TX && state_reg == SIOE_IDLE && room;
    endsequence
    sequence s_frame_open;
        ##[1:2] !spi_cs_n;
    endsequence

    a_tx_starts: assert property (s_tx_write |-> s_frame_open)
        else $error("Transmit write did not open a frame");
    a_edge_count: assert property ($rose(state_reg == SIOE_TAIL) |-> edge_reg == nedges)
        else $error("Wrong serial clock edge count");
    a_sclk_toggle: assert property (state_reg == SIOE_SHIFT && half_tick |=> spi_sclk != $past(spi_sclk))
        else $error("Serial clock missed a toggle");
    a_cs_hold: assert property (push && hold |=> !spi_cs_n)
        else $error("Chip select released despite hold");
    a_cs_release: assert property (push && !hold |=> spi_cs_n)
        else $error("Chip select not released");
    a_restart_set: assert property (push && cfg_reg[`SIOE_RESTART_BIT] |=> start_pend_reg)
        else $error("Automatic restart not armed");
    a_new_flag: assert property (push |=> fifo_cnt_reg != 2'h0)
        else $error("New data flag not set");
    a_flag_clear: assert property (pop && !push && fifo_cnt_reg == 2'h1 |=> fifo_cnt_reg == 2'h0)
        else $error("New data flag not cleared by read");
    a_idle_pol: assert property (state_reg == SIOE_IDLE |=> spi_sclk == $past(cpol))
        else $error("Idle clock level wrong");
    a_half_len: assert property (state_reg == SIOE_SHIFT && spi_sclk != sclk_last_reg
        && edge_reg > 9'h001 |-> sclk_age_reg == exp_half)
        else $error("Half period length wrong");
    a_mode_out: assert property (##1 led_mode == !$past(cfg_reg[`SIOE_MODE_BIT]))
        else $error("Mode output wrong");
endmodule : sioe_top

// [hdl/sioe_regs.svh]
`ifndef SIOE_REGS_SVH
`define SIOE_REGS_SVH
// Parameter addresses
`define SIOE_ADDR_CFG 9'h18c
`define SIOE_ADDR_TX 9'h18d
`define SIOE_ADDR_RX 9'h18e
// Configuration fields
`define SIOE_LEN_LSB 0
`define SIOE_LEN_MSB 7
`define SIOE_RESTART_BIT 9
`define SIOE_HOLD_BIT 10
`define SIOE_NEW_BIT 11
`define SIOE_CPOL_BIT 12
`define SIOE_CPHA_BIT 13
`define SIOE_PER_LSB 16
`define SIOE_PER_MSB 23
`define SIOE_MODE_BIT 28
`define SIOE_CFG_WMASK 32'h10ff36ff
// Reset values
`define SIOE_CFG_RST 32'h00000000
`define SIOE_TX_RST 32'h00000000
// Timing
`define SIOE_CLK_NS 20
`define SIOE_PER_UNIT_NS 100
`define SIOE_UNIT_CYC ((`SIOE_PER_UNIT_NS + `SIOE_CLK_NS - 1) / `SIOE_CLK_NS)
`endif

// [hdl/sioe_pkg.sv]
package sioe_pkg;
    typedef logic [31:0] sioe_word_t;
    typedef logic [8:0] sioe_addr_t;
    typedef enum logic [2:0] {
        SIOE_IDLE = 3'b000,
        SIOE_LEAD = 3'b001,
        SIOE_SHIFT = 3'b010,
        SIOE_TAIL = 3'b011,
        SIOE_DONE = 3'b100
    } sioe_state_e;
endpackage : sioe_pkg

// [verif/sioe_slave.sv]
`timescale 1ns/10ps
module sioe_slave (
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] len,
    input wire logic [31:0] reply,
    output logic spi_miso,
    output logic [31:0] got
);
    logic [31:0] sh;
    initial spi_miso = 1'b0;
    // Released line flips, never shows a stale bit
    always @(posedge spi_cs_n) spi_miso = ~spi_miso;
    always @(negedge spi_cs_n) begin
        got = 32'h0;
        sh = reply;
        if (!cpha) begin
            spi_miso = sh[len];
            sh = sh << 1;
        end
    end
    always @(spi_sclk) begin
        if (!spi_cs_n && ((spi_sclk != cpol) != cpha)) begin
            got = {got[30:0], spi_mosi};
        end else if (!spi_cs_n) begin
            spi_miso = sh[len];
            sh = sh << 1;
        end
    end
endmodule : sioe_slave

// [verif/tb_sioe_top.sv]
`timescale 1ns/10ps
`include "sioe_regs.svh"
module tb_sioe_top;
    import sioe_pkg::*;
    logic clk_sys = 0;
    logic nrst = 0;
    sioe_addr_t reg_addr = 9'h000;
    logic reg_wr = 0;
    logic reg_rd = 0;
    sioe_word_t reg_wdata = 32'h0;
    sioe_word_t reg_rdata, rpl = 32'h0, got, d;
    logic reg_rvalid, spi_sclk, spi_mosi, spi_cs_n, spi_miso, led_mode;
    logic cpol = 0, cpha = 0;
    logic [7:0] len = 8'h13;
    int bad_count = 0, n_checks = 0, edges = 0, low_cyc = 0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (!spi_cs_n) low_cyc++;
    always @(spi_sclk) if (!spi_cs_n) edges++;
    sioe_top u_sioe_top (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .led_mode(led_mode));
    sioe_slave u_sioe_slave (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .cpol(cpol), .cpha(cpha), .len(len), .reply(rpl), .spi_miso(spi_miso), .got(got));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        n_checks++;
        if (a !== e) begin
            bad_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : chk
    task automatic wr(input sioe_addr_t a, input sioe_word_t v);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input sioe_addr_t a, output sioe_word_t v);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk_sys);
        reg_rd = 0;
        chk(1, reg_rvalid);
        v = reg_rdata;
    endtask : rd
    // Bounded wait for chip select level
    task automatic wait_cs(input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            if (spi_cs_n === v) return;
        end
        bad_count++;
        finish_test();
    endtask : wait_cs
    // One frame with full readback
    task automatic frame(input sioe_word_t c, input sioe_word_t tx);
        sioe_word_t m;
        int h;
        m = 32'hffffffff >> (31 - c[7:0]);
        h = (c[23:16] * `SIOE_PER_UNIT_NS) / (2 * `SIOE_CLK_NS);
        if (h == 0) h = 1;
        len = c[7:0];
        cpol = c[12] & c[28];
        cpha = c[13] & c[28];
        rpl = ~tx;
        wr(`SIOE_ADDR_CFG, c);
        edges = 0;
        low_cyc = 0;
        wr(`SIOE_ADDR_TX, tx);
        wait_cs(0, 4);
        wait_cs(1, 900);
        chk(32'(2 * (c[7:0] + 1)), 32'(edges));
        chk(32'((2 * (c[7:0] + 1) + 2) * h + 1), 32'(low_cyc));
        chk(tx & m, got);
        chk(!c[28], led_mode);
        rd(`SIOE_ADDR_CFG, d);
        chk(1, d[11]);
        rd(`SIOE_ADDR_RX, d);
        chk(rpl & m, d);
        rd(`SIOE_ADDR_CFG, d);
        chk(0, d[11]);
    endtask : frame
    task automatic regs_check;
        rd(`SIOE_ADDR_CFG, d);
        chk(32'h0, d);
        rd(`SIOE_ADDR_TX, d);
        chk(32'h0, d);
        wr(9'h18f, 32'hffffffff);
        rd(9'h18f, d);
        chk(32'h0, d);
        chk(1, led_mode);
        wr(`SIOE_ADDR_CFG, 32'hffffffff);
        rd(`SIOE_ADDR_CFG, d);
        chk(32'h10ff36ff, d);
    endtask : regs_check
    task automatic hold_check;
        wr(`SIOE_ADDR_CFG, 32'h10020413);
        wr(`SIOE_ADDR_TX, 32'h5);
        for (int i = 0; i < 300 && !d[11]; i++) rd(`SIOE_ADDR_CFG, d);
        // Flag never came: give up
        if (!d[11]) begin
            bad_count++;
            finish_test();
        end
        chk(0, spi_cs_n);
        rd(`SIOE_ADDR_RX, d);
        chk(rpl & 32'hfffff, d);
        wr(`SIOE_ADDR_CFG, 32'h10020013);
        wait_cs(1, 4);
    endtask : hold_check
    // Buffer fills, link stalls, then drains
    task automatic restart_check;
        wr(`SIOE_ADDR_CFG, 32'h10020213);
        wr(`SIOE_ADDR_TX, 32'h9);
        wait_cs(0, 4);
        wait_cs(1, 900);
        wait_cs(0, 20);
        wait_cs(1, 900);
        edges = 0;
        repeat (300) @(negedge clk_sys);
        chk(0, 32'(edges));
        rd(`SIOE_ADDR_RX, d);
        chk(rpl & 32'hfffff, d);
        wait_cs(0, 20);
        wr(`SIOE_ADDR_CFG, 32'h10020013);
        wait_cs(1, 900);
        for (int i = 0; i < 2; i++) begin
            rd(`SIOE_ADDR_RX, d);
            chk(rpl & 32'hfffff, d);
        end
        rd(`SIOE_ADDR_CFG, d);
        chk(0, d[11]);
    endtask : restart_check
    initial begin
        repeat (4) @(negedge clk_sys);
        nrst = 1;
        regs_check();
        for (int k = 0; k < 4; k++) frame(32'h10020013 | (k << 12), 32'h0a5c3 ^ k);
        frame(32'h1002001f, 32'hc3a50f96);
        frame(32'h10020000, 32'h1);
        frame(32'h00023013, 32'h3c5a1);
        hold_check();
        restart_check();
        finish_test();
    end
endmodule : tb_sioe_top
